/* rtl/shc_pkg.sv */
// package of constants and types for the standby halt/stop controller
package shc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] SHC_SETTLE_ADDR = 16'hfff4;
  localparam logic [15:0] SHC_LSMODE_ADDR = 16'hfff5;
  localparam logic [15:0] SHC_STATUS_ADDR = 16'hfff6;
  localparam int SHC_SETTLE_SEL_LO = 0;
  localparam int SHC_SETTLE_SEL_HI = 1;
  localparam int SHC_LS_HALT_BIT = 0;
  localparam logic [1:0] SHC_SETTLE_RST = 2'h0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SHC_CLK_MHZ = 125;
  localparam int SHC_OPSTOP_MIN_US = 17;
  localparam int SHC_OPSTOP_CYC = SHC_OPSTOP_MIN_US * SHC_CLK_MHZ;
  localparam int SHC_OSC_START_CYC = 16;
  localparam int SHC_SETTLE_EXP0 = 10;
  localparam int SHC_SETTLE_EXP1 = 12;
  localparam int SHC_SETTLE_EXP2 = 15;
  localparam int SHC_SETTLE_EXP3 = 17;
  localparam int SHC_CNT_W = 18;
  localparam int SHC_WAKE_NOVEC_CYC = 4;
  localparam int SHC_WAKE_VEC_CYC = 12;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SHC_SRC_HSINT, SHC_SRC_XTAL, SHC_SRC_EXT} shc_src_t;
  typedef enum logic [1:0] {SHC_CMD_NONE, SHC_CMD_HALT, SHC_CMD_STOP} shc_cmd_t;
endpackage

/* rtl/shc_link_if.sv */
// interface between the standby controller and the cpu/interrupt side
`timescale 1ns/100ps
interface shc_link_if;
  logic [1:0] cmd;
  logic irq_pend;
  logic irq_accept_enable;
  logic cpu_clk_en;
  logic periph_clk_en;
  logic sys_osc_run;
  logic lowspeed_osc_run;
  logic hold_state;
  logic wake;
  logic wake_vector;
  modport dev (input cmd, input irq_pend, input irq_accept_enable,
    output cpu_clk_en, output periph_clk_en, output sys_osc_run,
    output lowspeed_osc_run, output hold_state, output wake, output wake_vector);
  modport cpu (output cmd, output irq_pend, output irq_accept_enable,
    input cpu_clk_en, input periph_clk_en, input sys_osc_run,
    input lowspeed_osc_run, input hold_state, input wake, input wake_vector);
endinterface

/* rtl/shc_standby_ctrl.sv */
// standby controller: halt and stop modes with post-stop settle wait for the crystal source
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module shc_standby_ctrl (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // option byte and clock source
  input wire shc_pkg::shc_src_t i_clk_src,
  input wire logic i_opt_ls_stoppable,
  input wire logic [1:0] i_opt_settle_sel,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // link to cpu side
  shc_link_if.dev link
);
  import shc_pkg::*;
  typedef enum {ST_RUN, ST_HALT, ST_STOP, ST_OSC_START, ST_SETTLE, ST_OPSTOP, ST_WAKE} shc_state_t;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  shc_state_t state_q, state_d;
  logic [1:0] settle_sel_q;
  logic lowspeed_osc_halt_bit_q;
  logic [SHC_CNT_W-1:0] cnt_q, cnt_d;
  logic vec_q, vec_d;
  logic [7:0] rdata_q;
  logic cpu_en_q, per_en_q, osc_q, ls_q, hold_q, wake_q, wvec_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_settle = i_wr && (i_addr == SHC_SETTLE_ADDR);
  wire wr_lsmode = i_wr && (i_addr == SHC_LSMODE_ADDR);
  wire [7:0] settle_rd = {6'h00, settle_sel_q};
  wire [7:0] lsmode_rd = {7'h00, lowspeed_osc_halt_bit_q};
  wire [7:0] status_rd = {4'h0, osc_q, ls_q, per_en_q, cpu_en_q};
  wire [7:0] rd_mux = (i_addr == SHC_SETTLE_ADDR) ? settle_rd :
                      (i_addr == SHC_LSMODE_ADDR) ? lsmode_rd :
                      (i_addr == SHC_STATUS_ADDR) ? status_rd : 8'h00;
  // ------------------------------------------------------------
  // low-speed oscillator
  // ------------------------------------------------------------
  // low-speed oscillator only stoppable when option permits
  wire ls_run = !(i_opt_ls_stoppable && lowspeed_osc_halt_bit_q);
  // a halt-bit write during standby must not stop a running oscillator;
  // the pin lets go once run resumes
  wire ls_pin = ls_q && (state_q != ST_RUN);
  wire ls_nx = ls_run || ls_pin;

  // ------------------------------------------------------------
  // settle selection
  // ------------------------------------------------------------
  wire xtal = (i_clk_src == SHC_SRC_XTAL);
  wire [SHC_CNT_W-1:0] settle_cyc =
    (settle_sel_q == 2'h0) ? SHC_CNT_W'(1 << SHC_SETTLE_EXP0) :
    (settle_sel_q == 2'h1) ? SHC_CNT_W'(1 << SHC_SETTLE_EXP1) :
    (settle_sel_q == 2'h2) ? SHC_CNT_W'(1 << SHC_SETTLE_EXP2) :
                             SHC_CNT_W'(1 << SHC_SETTLE_EXP3);
  wire cnt_done = (cnt_q == '0);

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
    vec_d = vec_q;
    case (state_q)
      ST_RUN: begin
        if (link.cmd == SHC_CMD_HALT) begin
          state_d = ST_HALT;
        end else if (link.cmd == SHC_CMD_STOP) begin
          state_d = ST_STOP;
        end
      end
      ST_HALT: begin
        // pending request on entry also releases here
        if (link.irq_pend) begin
          vec_d = link.irq_accept_enable;
          cnt_d = SHC_CNT_W'(link.irq_accept_enable ? SHC_WAKE_VEC_CYC : SHC_WAKE_NOVEC_CYC);
          state_d = ST_WAKE;
        end
      end
      ST_STOP: begin
        if (link.irq_pend) begin
          vec_d = link.irq_accept_enable;
          cnt_d = SHC_CNT_W'(SHC_OSC_START_CYC);
          state_d = ST_OSC_START;
        end
      end
      ST_OSC_START: begin
        // start-up delay is not part of the settle count
        if (cnt_done) begin
          if (xtal) begin
            cnt_d = settle_cyc;
            state_d = ST_SETTLE;
          end else begin
            cnt_d = SHC_CNT_W'(SHC_OPSTOP_CYC);
            state_d = ST_OPSTOP;
          end
        end
      end
      ST_SETTLE: begin
        if (cnt_done) begin
          cnt_d = SHC_CNT_W'(SHC_OPSTOP_CYC);
          state_d = ST_OPSTOP;
        end
      end
      ST_OPSTOP: begin
        if (cnt_done) begin
          cnt_d = SHC_CNT_W'(vec_q ? SHC_WAKE_VEC_CYC : SHC_WAKE_NOVEC_CYC);
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt_done) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // clock gates derived from next state so outputs stay registered
  wire nx_osc = (state_d != ST_STOP) && (state_d != ST_OSC_START);
  wire nx_per = (state_d == ST_RUN) || (state_d == ST_HALT) || (state_d == ST_WAKE);
  wire nx_cpu = (state_d == ST_RUN);
  wire nx_wake = (state_d == ST_WAKE) && (state_q != ST_WAKE);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= ST_RUN;
      cnt_q <= '0;
      vec_q <= 1'b0;
      lowspeed_osc_halt_bit_q <= 1'b0;
      rdata_q <= 8'h00;
      cpu_en_q <= 1'b1;
      per_en_q <= 1'b1;
      osc_q <= 1'b1;
      ls_q <= 1'b1;
      hold_q <= 1'b0;
      wake_q <= 1'b0;
      wvec_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      vec_q <= vec_d;
      if (wr_lsmode) begin
        lowspeed_osc_halt_bit_q <= i_wdata[SHC_LS_HALT_BIT];
      end
      rdata_q <= i_rd ? rd_mux : 8'h00;
      cpu_en_q <= nx_cpu;
      per_en_q <= nx_per;
      osc_q <= nx_osc;
      ls_q <= ls_nx;
      hold_q <= (state_d != ST_RUN);
      wake_q <= nx_wake;
      wvec_q <= nx_wake && vec_d;
    end
  end

  // settle select: reset loads SHC_SETTLE_RST (0), option byte governs reset wait
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      settle_sel_q <= SHC_SETTLE_RST;
    end else if (wr_settle) begin
      settle_sel_q <= {i_wdata[SHC_SETTLE_SEL_HI], i_wdata[SHC_SETTLE_SEL_LO]};
    end
  end

  assign o_rdata = rdata_q;
  assign link.cpu_clk_en = cpu_en_q;
  assign link.periph_clk_en = per_en_q;
  assign link.sys_osc_run = osc_q;
  assign link.lowspeed_osc_run = ls_q;
  assign link.hold_state = hold_q;
  assign link.wake = wake_q;
  assign link.wake_vector = wvec_q;
  // reset-time settle is applied by the reset logic from the option byte
  wire unused_opt = ^i_opt_settle_sel;
endmodule // shc_standby_ctrl

/* rtl/shc_cpu_end.sv */
// cpu/interrupt end: issues standby commands and reports pending requests
`timescale 1ns/100ps
module shc_cpu_end (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // user side
  input wire logic i_halt_req,
  input wire logic i_stop_req,
  input wire logic [7:0] i_irq_flag,
  input wire logic [7:0] i_irq_mask_flag,
  input wire logic i_irq_accept_enable,
  output logic o_cpu_run,
  output logic o_wake,
  output logic o_wake_vector,
  // link to controller
  shc_link_if.cpu link
);
  import shc_pkg::*;
  logic [1:0] cmd_q;
  logic pend_q, ie_q, run_q, wake_q, wvec_q;
  // unmasked request pending
  wire pend_d = |(i_irq_flag & ~i_irq_mask_flag);
  // a command is only issued from run; software quiesces peripherals first
  wire [1:0] cmd_d = !link.cpu_clk_en ? SHC_CMD_NONE :
                     i_stop_req ? SHC_CMD_STOP :
                     i_halt_req ? SHC_CMD_HALT : SHC_CMD_NONE;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cmd_q <= SHC_CMD_NONE;
      pend_q <= 1'b0;
      ie_q <= 1'b0;
      run_q <= 1'b0;
      wake_q <= 1'b0;
      wvec_q <= 1'b0;
    end else begin
      cmd_q <= (cmd_q == SHC_CMD_NONE) ? cmd_d : SHC_CMD_NONE;
      pend_q <= pend_d;
      ie_q <= i_irq_accept_enable;
      run_q <= link.cpu_clk_en;
      wake_q <= link.wake;
      wvec_q <= link.wake_vector;
    end
  end
  assign link.cmd = cmd_q;
  assign link.irq_pend = pend_q;
  assign link.irq_accept_enable = ie_q;
  assign o_cpu_run = run_q;
  assign o_wake = wake_q;
  assign o_wake_vector = wvec_q;
endmodule // shc_cpu_end

/* tb/shc_link_chk.sv */
// assertion checker for the standby link
`timescale 1ns/100ps
module shc_link_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // link signals
  input wire logic [1:0] cmd,
  input wire logic irq_pend,
  input wire logic irq_accept_enable,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic sys_osc_run,
  input wire logic lowspeed_osc_run,
  input wire logic hold_state,
  input wire logic wake,
  input wire logic wake_vector
);
  logic [11:0] rec_q;
  logic [11:0] rec_d;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // saturates so a long settle wait cannot wrap
  assign rec_d = !sys_osc_run ? 12'h000 :
    (!periph_clk_en && rec_q != 12'hfff) ? rec_q + 12'h001 : rec_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rec_q <= 12'h000;
    end else begin
      rec_q <= rec_d;
    end
  end
  a_halt_gate: assert property (cpu_clk_en && cmd == 2'h1 |=>
    !cpu_clk_en && hold_state && periph_clk_en && sys_osc_run) else $error("halt gating");
  a_halt_ls: assert property (!cpu_clk_en && periph_clk_en && $past(lowspeed_osc_run)
    |-> lowspeed_osc_run) else $error("ls lost in halt");
  a_stop_off: assert property (cpu_clk_en && cmd == 2'h2 |=>
    !cpu_clk_en && !periph_clk_en && !sys_osc_run) else $error("stop gating");
  a_stop_ls: assert property (!sys_osc_run && $past(lowspeed_osc_run)
    |-> lowspeed_osc_run) else $error("ls lost in stop");
  a_opstop_min: assert property ($rose(periph_clk_en) |-> rec_q >= 12'h84d)
    else $error("opstop short");
  a_halt_wake: assert property ($rose(irq_pend) && !cpu_clk_en && periph_clk_en
    |-> ##[1:2] wake) else $error("no halt wake");
  a_novec_time: assert property (wake && !wake_vector |->
    !cpu_clk_en [*3] ##[1:4] cpu_clk_en) else $error("resume time");
  a_vec_time: assert property (wake && wake_vector |->
    !cpu_clk_en [*8] ##[4:7] cpu_clk_en) else $error("vector time");
  a_vec_ie: assert property (wake |-> wake_vector == irq_accept_enable)
    else $error("vector select");
endmodule // shc_link_chk

/* tb/test_standby_halt_stop_control.sv */
// self-checking bench for both ends of the standby link
`timescale 1ns/100ps
module test_standby_halt_stop_control;
  import shc_pkg::*;
  logic clk, cpu_run, wk, wkv;
  logic rst_n = 1'b0, ls_ok = 1'b1, wr = 1'b0, rd = 1'b0, ie = 1'b0;
  logic halt_req = 1'b0, stop_req = 1'b0;
  shc_src_t src = SHC_SRC_HSINT;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, flag = 8'h00, mask = 8'h00;
  int error_cnt = 0, n_compared = 0, n;
  shc_link_if lk ();
  shc_standby_ctrl shc_standby_ctrl_i (.i_mclk(clk), .i_rst_n(rst_n), .i_clk_src(src),
    .i_opt_ls_stoppable(ls_ok), .i_opt_settle_sel(2'h0), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(lk.dev));
  shc_cpu_end shc_cpu_end_i (.i_mclk(clk), .i_rst_n(rst_n), .i_halt_req(halt_req),
    .i_stop_req(stop_req), .i_irq_flag(flag), .i_irq_mask_flag(mask),
    .i_irq_accept_enable(ie), .o_cpu_run(cpu_run), .o_wake(wk), .o_wake_vector(wkv),
    .link(lk.cpu));
  shc_link_chk shc_link_chk_i (.i_mclk(clk), .i_rst_n(rst_n), .cmd(lk.cmd),
    .irq_pend(lk.irq_pend), .irq_accept_enable(lk.irq_accept_enable),
    .cpu_clk_en(lk.cpu_clk_en), .periph_clk_en(lk.periph_clk_en),
    .sys_osc_run(lk.sys_osc_run), .lowspeed_osc_run(lk.lowspeed_osc_run),
    .hold_state(lk.hold_state), .wake(lk.wake), .wake_vector(lk.wake_vector));
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %s exp %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return lk.cpu_clk_en;
      1: return lk.sys_osc_run;
      2: return lk.periph_clk_en;
      default: return wk;
    endcase
  endfunction
  // bounded poll; n returns the cycles spent
  task automatic wt(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v) begin
      if (n == lim) begin
        chk("wait", 1, 1, 0);
        tally_and_finish();
      end
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, e, rdata);
  endtask
  task automatic halt_run(input logic v, input int lo, input int hi);
    @(posedge clk);
    ie <= v;
    mask <= 8'h01;
    flag <= 8'h01;
    halt_req <= 1'b1;
    wt(0, 1'b0, 20);
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chk("masked_hold", 0, 0, cpu_run);
    @(posedge clk);
    mask <= 8'h00;
    wt(3, 1'b1, 10);
    chk("vector", v, v, wkv);
    wt(0, 1'b1, 20);
    chk("resume", lo, hi, n);
    @(posedge clk);
    flag <= 8'h00;
  endtask
  // lo is the earliest legal gap from oscillation start to peripheral clock
  task automatic stop_run(input shc_src_t s, input logic [1:0] sel, input int lo);
    wreg(SHC_SETTLE_ADDR, {6'h00, sel});
    @(posedge clk);
    src <= s;
    stop_req <= 1'b1; // peripherals already quiesced by software
    wt(0, 1'b0, 20);
    @(posedge clk);
    stop_req <= 1'b0;
    flag <= 8'h02;
    wt(1, 1'b1, 60);
    wt(2, 1'b1, 40000);
    chk("settle", lo, lo + 5, n);
    wt(0, 1'b1, 30);
    @(posedge clk);
    flag <= 8'h00;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wreg(SHC_SETTLE_ADDR, 8'hff);
    rreg(SHC_SETTLE_ADDR, 8'h03);
    rreg(16'hfff0, 8'h00);
    wreg(SHC_LSMODE_ADDR, 8'h01);
    rreg(SHC_STATUS_ADDR, 8'h0b);
    @(posedge clk);
    ls_ok <= 1'b0;
    rreg(SHC_STATUS_ADDR, 8'h0f);
    wreg(SHC_LSMODE_ADDR, 8'h00);
    halt_run(1'b0, 2, 5);
    halt_run(1'b1, 10, 13);
    // unmasked request already pending: halt must not stick
    @(posedge clk);
    flag <= 8'h01;
    halt_req <= 1'b1;
    repeat (3) @(posedge clk);
    halt_req <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chk("pend_release", 1, 1, cpu_run);
    @(posedge clk);
    flag <= 8'h00;
    stop_run(SHC_SRC_HSINT, 2'h3, SHC_OPSTOP_CYC);
    stop_run(SHC_SRC_EXT, 2'h2, SHC_OPSTOP_CYC);
    stop_run(SHC_SRC_XTAL, 2'h0, (1 << SHC_SETTLE_EXP0) + SHC_OPSTOP_CYC);
    stop_run(SHC_SRC_XTAL, 2'h1, (1 << SHC_SETTLE_EXP1) + SHC_OPSTOP_CYC);
    stop_run(SHC_SRC_XTAL, 2'h2, (1 << SHC_SETTLE_EXP2) + SHC_OPSTOP_CYC);
    rreg(SHC_SETTLE_ADDR, 8'h02);
    // halt bit written while stopped: running low-speed oscillator stays on
    @(posedge clk);
    ls_ok <= 1'b1;
    stop_req <= 1'b1;
    wt(0, 1'b0, 20);
    @(posedge clk);
    stop_req <= 1'b0;
    wreg(SHC_LSMODE_ADDR, 8'h01);
    rreg(SHC_STATUS_ADDR, 8'h04);
    // reset ends stop; held past the clock enables' rise so no false edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rreg(SHC_STATUS_ADDR, 8'h0f);
    chk("rst_cpu", 1, 1, cpu_run);
    tally_and_finish();
  end
endmodule // test_standby_halt_stop_control
